// *** hw/tpm_pkg.sv ***
package tpm_pkg;
  localparam int CNT_N = 6;
  localparam int CNT_W = 8;
  localparam int WD_W = 16;
  localparam int AW = 8;
  localparam int IDX_PS = 0;
  localparam int IDX_T1 = 1;
  localparam int IDX_T3 = 3;
  localparam int IDX_T4 = 4;
  localparam logic [AW-1:0] OFF_CTRL = 8'h00;
  localparam logic [AW-1:0] OFF_SRC = 8'h04;
  localparam logic [AW-1:0] OFF_CMD = 8'h08;
  localparam logic [AW-1:0] OFF_STAT = 8'h0C;
  localparam logic [AW-1:0] OFF_IRQ0C = 8'h10;
  localparam logic [AW-1:0] OFF_CAPT = 8'h14;
  localparam logic [AW-1:0] OFF_T4H = 8'h18;
  localparam logic [AW-1:0] OFF_CNT = 8'h20;
  localparam logic [AW-1:0] OFF_RLD = 8'h40;
  localparam logic [AW-1:0] OFF_SPAN = 8'h18;
  localparam int B_PM_EN = 6;
  localparam int B_T4OE = 7;
  localparam int B_PWMX = 8;
  localparam int B_WEF = 9;
  localparam int B_MSEL = 10;
  localparam int B_WDIS = 0;
  localparam int B_WATCHDOG_RESTART_OP = 1;
  localparam int B_WATCHDOG_FIRST_FLAG = 8;
  localparam int B_WACT = 9;
  localparam int B_SYNC = 0;
  localparam int B_PINEN = 3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0200;
  localparam logic [1:0] SRC_SYS = 2'h0;
  localparam logic [1:0] SRC_PS = 2'h1;
  localparam logic [1:0] SRC_PIN = 2'h2;
  localparam logic [1:0] SRC_CHAIN = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {PM_IDLE, PM_WAIT, PM_MEAS} tpm_pm_t;
endpackage

// *** hw/tpm_cnt_if.sv ***
// Control and state of one down counter.
interface tpm_cnt_if #(parameter int W = 8);
  logic run;
  logic need_fall;
  logic rise;
  logic fall;
  logic load;
  logic [W-1:0] load_val;
  logic [W-1:0] reload_val;
  logic [W-1:0] count;
  logic underflow;
  modport ctl (output run, need_fall, rise, fall, load, load_val, reload_val,
    input count, underflow);
  modport cnt (input run, need_fall, rise, fall, load, load_val, reload_val,
    output count, underflow);
endinterface

// *** hw/tpm_counter.sv ***
// One reloading down counter stepped by count source edges.
module tpm_counter #(parameter int W = 8) (
  input wire logic aclk,
  input wire logic aresetn,
  tpm_cnt_if.cnt c
);
  logic run_d_reg;
  logic armed_reg;
  logic [W-1:0] count_reg;
  logic uf_reg;
  logic tick;

  // Counting starts on the first qualifying rise, so the first period may be short.
  assign tick = c.run && (armed_reg || !c.need_fall) && c.rise;
  assign c.count = count_reg;
  assign c.underflow = uf_reg;

  // Remembers the run level to spot a start.
  always_ff @(posedge aclk) begin
    if (!aresetn) run_d_reg <= 1'b0;
    else run_d_reg <= c.run;
  end

  // A counter that waits for a fall is armed only once the source has fallen.
  always_ff @(posedge aclk) begin
    if (!aresetn) armed_reg <= 1'b0;
    else if (!c.run || !run_d_reg) armed_reg <= c.run && c.fall;
    else if (c.fall) armed_reg <= 1'b1;
  end

  // Down count with reload at zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= '0;
      uf_reg <= 1'b0;
    end else begin
      uf_reg <= tick && (count_reg == '0);
      if (c.load) count_reg <= c.load_val;
      else if (tick && count_reg == '0) count_reg <= c.reload_val;
      else if (tick) count_reg <= count_reg - 1'b1;
    end
  end

  a_uf_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    (tick && count_reg == '0 && !c.load) |=> (uf_reg && count_reg == $past(c.reload_val)))
    else $error("Underflow did not reload the counter.");
  a_wait_fall: assert property (@(posedge aclk) disable iff (!aresetn)
    (c.need_fall && !armed_reg && !c.load) |=> count_reg == $past(count_reg))
    else $error("Counter moved before the first source fall.");
  a_first_rise: assert property (@(posedge aclk) disable iff (!aresetn)
    (c.run && !c.need_fall && c.rise && count_reg != '0 && !c.load)
      |=> count_reg == W'($past(count_reg) - 1'b1))
    else $error("Counter missed a source rise.");
endmodule // tpm_counter

// *** hw/tpm_top.sv ***
// Timer block with period measurement and watchdog behind an AXI4-Lite slave.
module tpm_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [tpm_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tpm_pkg::AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic counter_pin_a,
  input wire logic counter_pin_b_in,
  output logic counter_pin_b_out,
  output logic counter_pin_b_oe,
  input wire logic ext_irq_pin_zero,
  input wire logic backup_return,
  output logic wd_reset_req
);
  localparam int N = tpm_pkg::CNT_N;
  localparam int W = tpm_pkg::CNT_W;

  logic aw_have_reg, w_have_reg, bvalid_reg, awready_reg, wready_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg, rd_next, wdata_reg, wmask;
  logic [tpm_pkg::AW-1:0] awaddr_reg;
  logic [31:0] ctrl_reg, src_reg;
  logic [3:0] irq0c_reg;
  logic [N-1:0] flags_reg, flag_set, flag_clr, uf, run_eff, ld, src_prev_reg;
  logic [W-1:0] reload_reg [N];
  logic [W-1:0] cnt_val [N];
  logic [W-1:0] t4h_reg, capt_reg;
  logic wr_fire, wr_ok, rd_ok, ps_lvl_reg, meas_prev_reg, meas_lvl, meas_edge, pm_load, pm_set;
  logic t4_out_reg, t4_oe_reg, wd_req_reg, wd_act_reg, wd_dis_reg, watchdog_first_flag_reg, wd_ovf;
  logic wr_cmd, wr_rst;
  localparam int WD_W_L = tpm_pkg::WD_W;
  logic [WD_W_L-1:0] wd_cnt_reg;
  logic [3:0] s_axi_wstrb_q;
  logic [tpm_pkg::AW-1:0] wr_rel, rd_rel;
  tpm_pkg::tpm_pm_t pm_state;

  tpm_cnt_if #(.W(W)) cif [N] ();

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign counter_pin_b_out = t4_out_reg;
  assign counter_pin_b_oe = t4_oe_reg;
  assign wd_reset_req = wd_req_reg;

  // Each counter takes its source level; the system clock counts every cycle.
  for (genvar i = 0; i < N; i++) begin : g_cnt
    logic [1:0] code;
    logic lvl;
    assign code = (i == tpm_pkg::IDX_PS) ? tpm_pkg::SRC_SYS : src_reg[2*i +: 2];
    always_comb begin
      unique case (code)
        tpm_pkg::SRC_SYS: lvl = 1'b1;
        tpm_pkg::SRC_PS: lvl = ps_lvl_reg;
        tpm_pkg::SRC_PIN: lvl = (i == tpm_pkg::IDX_T3 || i == tpm_pkg::IDX_T4) ?
          counter_pin_b_in : counter_pin_a;
        tpm_pkg::SRC_CHAIN: lvl = (i == 0) ? 1'b0 : uf[(i == 0) ? 0 : i-1];
      endcase
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) src_prev_reg[i] <= 1'b0;
      else src_prev_reg[i] <= lvl;
    end
    assign cif[i].run = run_eff[i];
    assign cif[i].need_fall = (i == tpm_pkg::IDX_T4);
    assign cif[i].rise = (code == tpm_pkg::SRC_SYS) || (lvl && !src_prev_reg[i]);
    assign cif[i].fall = (code == tpm_pkg::SRC_SYS) || (!lvl && src_prev_reg[i]);
    assign cif[i].load = ld[i];
    assign cif[i].load_val = (i == tpm_pkg::IDX_T1 && pm_load) ? reload_reg[i] : wdata_reg[W-1:0];
    assign cif[i].reload_val = (i == tpm_pkg::IDX_T4 && ctrl_reg[tpm_pkg::B_PWMX] && !t4_out_reg)
      ? t4h_reg : reload_reg[i];
    assign uf[i] = cif[i].underflow;
    assign cnt_val[i] = cif[i].count;
    tpm_counter #(.W(W)) u_cnt (.aclk(aclk), .aresetn(aresetn), .c(cif[i]));
  end

  // Timer one only runs in measurement once the first edge has been seen.
  always_comb begin
    run_eff = ctrl_reg[N-1:0];
    run_eff[tpm_pkg::IDX_T1] = ctrl_reg[tpm_pkg::IDX_T1] &&
      (!ctrl_reg[tpm_pkg::B_PM_EN] || pm_state == tpm_pkg::PM_MEAS);
  end

  // Bus write decode; strobes pick the byte lanes that change.
  assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
  assign wr_rel = awaddr_reg - tpm_pkg::OFF_CNT;
  assign rd_rel = s_axi_araddr - tpm_pkg::OFF_CNT;
  assign wmask = {{8{s_axi_wstrb_q[3]}}, {8{s_axi_wstrb_q[2]}}, {8{s_axi_wstrb_q[1]}},
    {8{s_axi_wstrb_q[0]}}};
  assign wr_cmd = wr_fire && awaddr_reg == tpm_pkg::OFF_CMD && s_axi_wstrb_q[0];
  assign wr_rst = wr_cmd && wdata_reg[tpm_pkg::B_WATCHDOG_RESTART_OP];
  always_comb begin
    wr_ok = awaddr_reg[1:0] == 2'h0 && (awaddr_reg <= tpm_pkg::OFF_T4H ||
      (awaddr_reg >= tpm_pkg::OFF_CNT && wr_rel < tpm_pkg::OFF_SPAN) ||
      (awaddr_reg >= tpm_pkg::OFF_RLD && awaddr_reg - tpm_pkg::OFF_RLD < tpm_pkg::OFF_SPAN));
    ld = '0;
    flag_clr = '0;
    if (wr_fire && awaddr_reg >= tpm_pkg::OFF_CNT && wr_rel < tpm_pkg::OFF_SPAN &&
        s_axi_wstrb_q[0]) ld[wr_rel[4:2]] = 1'b1;
    if (wr_fire && awaddr_reg == tpm_pkg::OFF_STAT && s_axi_wstrb_q[0]) begin
      flag_clr = wdata_reg[N-1:0];
    end
    ld[tpm_pkg::IDX_T1] = ld[tpm_pkg::IDX_T1] || pm_load;
  end

  // Write channel: address and data are taken in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= tpm_pkg::RESP_OKAY;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      s_axi_wstrb_q <= '0;
    end else begin
      if (s_axi_awvalid && awready_reg) begin
        aw_have_reg <= 1'b1;
        awready_reg <= 1'b0;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_reg) begin
        w_have_reg <= 1'b1;
        wready_reg <= 1'b0;
        wdata_reg <= s_axi_wdata;
        s_axi_wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok ? tpm_pkg::RESP_OKAY : tpm_pkg::RESP_SLVERR;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // Software registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= tpm_pkg::CTRL_RST;
      src_reg <= '0;
      irq0c_reg <= '0;
      t4h_reg <= '0;
      for (int i = 0; i < N; i++) reload_reg[i] <= '0;
    end else if (wr_fire) begin
      if (awaddr_reg == tpm_pkg::OFF_CTRL) ctrl_reg <= (ctrl_reg & ~wmask) | (wdata_reg & wmask);
      if (awaddr_reg == tpm_pkg::OFF_SRC) src_reg <= (src_reg & ~wmask) | (wdata_reg & wmask);
      if (awaddr_reg == tpm_pkg::OFF_IRQ0C && s_axi_wstrb_q[0]) irq0c_reg <= wdata_reg[3:0];
      if (awaddr_reg == tpm_pkg::OFF_T4H && s_axi_wstrb_q[0]) t4h_reg <= wdata_reg[W-1:0];
      if (awaddr_reg >= tpm_pkg::OFF_RLD && awaddr_reg - tpm_pkg::OFF_RLD < tpm_pkg::OFF_SPAN &&
          s_axi_wstrb_q[0]) begin
        reload_reg[awaddr_reg[4:2] - tpm_pkg::OFF_RLD[4:2]] <= wdata_reg[W-1:0];
      end
    end
  end

  // Read channel: one answer a cycle after the address is taken.
  always_comb begin
    rd_ok = 1'b1;
    rd_next = '0;
    if (s_axi_araddr == tpm_pkg::OFF_CTRL) rd_next = ctrl_reg;
    else if (s_axi_araddr == tpm_pkg::OFF_SRC) rd_next = src_reg;
    else if (s_axi_araddr == tpm_pkg::OFF_CMD) rd_next = '0;
    else if (s_axi_araddr == tpm_pkg::OFF_STAT) begin
      rd_next[N-1:0] = flags_reg;
      rd_next[tpm_pkg::B_WATCHDOG_FIRST_FLAG] = watchdog_first_flag_reg;
      rd_next[tpm_pkg::B_WACT] = wd_act_reg;
    end else if (s_axi_araddr == tpm_pkg::OFF_IRQ0C) rd_next[3:0] = irq0c_reg;
    else if (s_axi_araddr == tpm_pkg::OFF_CAPT) rd_next[W-1:0] = capt_reg;
    else if (s_axi_araddr == tpm_pkg::OFF_T4H) rd_next[W-1:0] = t4h_reg;
    else if (s_axi_araddr >= tpm_pkg::OFF_CNT && rd_rel < tpm_pkg::OFF_SPAN &&
      s_axi_araddr[1:0] == 2'h0) rd_next[W-1:0] = cnt_val[rd_rel[4:2]];
    else if (s_axi_araddr >= tpm_pkg::OFF_RLD &&
      s_axi_araddr - tpm_pkg::OFF_RLD < tpm_pkg::OFF_SPAN &&
      s_axi_araddr[1:0] == 2'h0) rd_next[W-1:0] = reload_reg[s_axi_araddr[4:2]];
    else rd_ok = 1'b0;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= tpm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_next;
      rresp_reg <= rd_ok ? tpm_pkg::RESP_OKAY : tpm_pkg::RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // Prescaler output is a square wave toggled at each prescaler underflow.
  always_ff @(posedge aclk) begin
    if (!aresetn) ps_lvl_reg <= 1'b0;
    else if (uf[tpm_pkg::IDX_PS]) ps_lvl_reg <= !ps_lvl_reg;
  end

  // Timer four output toggles only on underflow taken while running, so a stop never glitches.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t4_out_reg <= 1'b0;
      t4_oe_reg <= 1'b0;
    end else begin
      t4_oe_reg <= ctrl_reg[tpm_pkg::B_T4OE];
      if (uf[tpm_pkg::IDX_T4] && run_eff[tpm_pkg::IDX_T4]) begin
        t4_out_reg <= !t4_out_reg;
      end
    end
  end

  // Measurement edge on the chosen input.
  assign meas_lvl = ctrl_reg[tpm_pkg::B_MSEL] ? counter_pin_a :
    (irq0c_reg[tpm_pkg::B_PINEN] && ext_irq_pin_zero);
  assign meas_edge = meas_lvl && !meas_prev_reg;
  assign pm_load = meas_edge && ((pm_state == tpm_pkg::PM_WAIT && ctrl_reg[tpm_pkg::IDX_T1]) ||
    pm_state == tpm_pkg::PM_MEAS);
  assign pm_set = pm_state == tpm_pkg::PM_MEAS && (meas_edge || !ctrl_reg[tpm_pkg::B_PM_EN]);

  // Measurement sequencer: wait for a first edge with timer one running, then time edges.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pm_state <= tpm_pkg::PM_IDLE;
      meas_prev_reg <= 1'b0;
      capt_reg <= '0;
    end else begin
      meas_prev_reg <= meas_lvl;
      if (pm_state == tpm_pkg::PM_MEAS && meas_edge) capt_reg <= cnt_val[tpm_pkg::IDX_T1];
      unique case (pm_state)
        tpm_pkg::PM_IDLE: if (ctrl_reg[tpm_pkg::B_PM_EN]) pm_state <= tpm_pkg::PM_WAIT;
        tpm_pkg::PM_WAIT: begin
          if (!ctrl_reg[tpm_pkg::B_PM_EN]) pm_state <= tpm_pkg::PM_IDLE;
          else if (pm_load) pm_state <= tpm_pkg::PM_MEAS;
        end
        tpm_pkg::PM_MEAS: begin
          if (!ctrl_reg[tpm_pkg::B_PM_EN]) pm_state <= tpm_pkg::PM_IDLE;
        end
      endcase
    end
  end

  // Request flags: set beats a write-one clear in the same cycle.
  always_comb begin
    flag_set = uf;
    flag_set[tpm_pkg::IDX_T1] = (uf[tpm_pkg::IDX_T1] && !ctrl_reg[tpm_pkg::B_PM_EN]) ||
      pm_set;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) flags_reg <= '0;
    else flags_reg <= (flags_reg & ~flag_clr) | flag_set;
  end

  // Watchdog: live from reset and after back-up; disable then restart stops it.
  assign wd_ovf = wd_act_reg && (&wd_cnt_reg);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_act_reg <= 1'b1;
      wd_dis_reg <= 1'b0;
      watchdog_first_flag_reg <= 1'b0;
      wd_req_reg <= 1'b0;
      wd_cnt_reg <= '0;
    end else begin
      wd_req_reg <= wd_ovf && watchdog_first_flag_reg && !wr_rst;
      if (wr_cmd) wd_dis_reg <= wdata_reg[tpm_pkg::B_WDIS] && !wdata_reg[tpm_pkg::B_WATCHDOG_RESTART_OP];
      if (backup_return) wd_act_reg <= 1'b1;
      else if (wr_rst && wd_dis_reg) wd_act_reg <= 1'b0;
      if (wr_rst) wd_cnt_reg <= '0;
      else if (wd_act_reg) wd_cnt_reg <= wd_cnt_reg + 1'b1;
      if (wd_ovf) watchdog_first_flag_reg <= 1'b1; // An overflow beats a restart in the same cycle.
      else if (wr_rst) watchdog_first_flag_reg <= 1'b0;
    end
  end

  a_pm_no_uf: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_reg[tpm_pkg::B_PM_EN] && !pm_set && !flags_reg[tpm_pkg::IDX_T1])
      |=> !flags_reg[tpm_pkg::IDX_T1])
    else $error("Timer one flag set by underflow in measurement.");
  a_pm_early_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    (pm_state == tpm_pkg::PM_WAIT && !ctrl_reg[tpm_pkg::IDX_T1]) |=> pm_state != tpm_pkg::PM_MEAS)
    else $error("Measurement started without timer one running.");
  a_pm_stop_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (pm_state == tpm_pkg::PM_MEAS && !ctrl_reg[tpm_pkg::B_PM_EN])
      |=> flags_reg[tpm_pkg::IDX_T1] && pm_state == tpm_pkg::PM_IDLE)
    else $error("Measurement stop did not flag and idle.");
  a_t4_stop_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !run_eff[tpm_pkg::IDX_T4] |=> $stable(t4_out_reg))
    else $error("Timer four output moved while stopped.");
  sequence s_wd_dis;
    wr_cmd && wdata_reg[tpm_pkg::B_WDIS] && !wdata_reg[tpm_pkg::B_WATCHDOG_RESTART_OP];
  endsequence
  sequence s_wd_rst;
    wr_rst && !backup_return;
  endsequence
  // The disable op arms the stop; the next restart op then halts the watchdog.
  a_wd_dis_arm: assert property (@(posedge aclk) disable iff (!aresetn)
    s_wd_dis |=> wd_dis_reg)
    else $error("Disable op did not arm the watchdog stop.");
  a_wd_pair_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    (wd_dis_reg ##0 s_wd_rst) |=> !wd_act_reg)
    else $error("Disable then restart left the watchdog running.");
  a_wd_reset_on: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> wd_act_reg)
    else $error("Watchdog not active after reset.");
  a_wd_backup: assert property (@(posedge aclk) disable iff (!aresetn)
    backup_return |=> wd_act_reg ##1 (wd_cnt_reg != '0 || wr_rst))
    else $error("Watchdog not revived after back-up.");
  a_bus_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_awvalid && awready_reg && s_axi_wvalid && wready_reg) |=> ##1 bvalid_reg)
    else $error("Write answer not given two cycles after taking both channels.");
endmodule // tpm_top

// *** tb/tpm_sw_model.sv ***
// Core software stand-in that issues register operations over AXI4-Lite.
module tpm_sw_model (
  input wire logic aclk,
  output logic [tpm_pkg::AW-1:0] awaddr = '0,
  output logic awvalid = 1'b0,
  input wire logic awready,
  output logic [31:0] wdata = 32'h0,
  output logic [3:0] wstrb = 4'hF,
  output logic wvalid = 1'b0,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready = 1'b0,
  output logic [tpm_pkg::AW-1:0] araddr = '0,
  output logic arvalid = 1'b0,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;

  // One write; address and data are offered together and each is held until taken.
  task automatic wr(input logic [tpm_pkg::AW-1:0] a, input logic [31:0] d,
    output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask

  // One read; the address stands until taken and rready until the data arrives.
  task automatic rd(input logic [tpm_pkg::AW-1:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule // tpm_sw_model

// *** tb/tpm_top_tb.sv ***
// Self-checking bench for the timer block.
module tpm_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [tpm_pkg::AW-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, b_out, b_oe, wd_req;
  logic pin_a = 1'b0;
  logic irq_pin = 1'b0;
  logic bk_ret = 1'b0;
  int failures = 0;
  int comparisons = 0;

  tpm_sw_model u_tpm_sw_model (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // The shared pin reads low (pull-down) unless the block drives it.
  tpm_top u_tpm_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .counter_pin_a(pin_a), .counter_pin_b_in(b_oe ? b_out : 1'b0),
    .counter_pin_b_out(b_out), .counter_pin_b_oe(b_oe), .ext_irq_pin_zero(irq_pin),
    .backup_return(bk_ret), .wd_reset_req(wd_req));

  // Clock of 50 ns period.
  initial begin
    forever #25 aclk = ~aclk;
  end

  // Compares one value and reports a difference.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_tpm_sw_model.wr(a, d, resp);
  endtask

  // Reads a register and compares the masked value.
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    u_tpm_sw_model.rd(a, rd, resp);
    chk(rd & m, e);
  endtask

  // One rising edge on the measured pin, held long enough to be seen.
  task automatic meas_edge();
    @(posedge aclk) irq_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    irq_pin <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  task automatic t_reset();
    rchk(tpm_pkg::OFF_CTRL, 32'hFFFF_FFFF, tpm_pkg::CTRL_RST);
    rchk(tpm_pkg::OFF_STAT, 32'h0000_0200, 32'h0000_0200);
  endtask

  // Disable then restart stops the watchdog; a back-up return wakes it again.
  task automatic t_wdog();
    wr(tpm_pkg::OFF_CMD, 32'h0000_0001);
    wr(tpm_pkg::OFF_CMD, 32'h0000_0002);
    wr(tpm_pkg::OFF_CTRL, 32'h0000_0000);
    rchk(tpm_pkg::OFF_STAT, 32'h0000_0200, 32'h0);
    rchk(tpm_pkg::OFF_CTRL, 32'hFFFF_FFFF, 32'h0);
    chk({31'h0, wd_req}, 32'h0);
    wr(tpm_pkg::OFF_CMD, 32'h0000_0002);
    rchk(tpm_pkg::OFF_STAT, 32'h0000_0100, 32'h0);
    @(posedge aclk) bk_ret <= 1'b1;
    @(posedge aclk) bk_ret <= 1'b0;
    rchk(tpm_pkg::OFF_STAT, 32'h0000_0200, 32'h0000_0200);
    wr(tpm_pkg::OFF_CMD, 32'h0000_0001);
    wr(tpm_pkg::OFF_CMD, 32'h0000_0002);
    rchk(tpm_pkg::OFF_STAT, 32'h0000_0200, 32'h0);
  endtask

  // Timer two loaded while stopped holds its count, then counts down and reloads.
  task automatic t_count();
    wr(tpm_pkg::OFF_SRC, 32'h0);
    wr(tpm_pkg::OFF_RLD + 8'h08, 32'h0000_0003);
    wr(tpm_pkg::OFF_CNT + 8'h08, 32'h0000_0010);
    repeat (5) @(posedge aclk);
    rchk(tpm_pkg::OFF_CNT + 8'h08, 32'hFFFF_FFFF, 32'h0000_0010);
    wr(tpm_pkg::OFF_CTRL, 32'h0000_0004);
    repeat (40) @(posedge aclk);
    wr(tpm_pkg::OFF_CTRL, 32'h0);
    rchk(tpm_pkg::OFF_STAT, 32'h0000_0004, 32'h0000_0004);
    u_tpm_sw_model.rd(tpm_pkg::OFF_CNT + 8'h08, rd, resp);
    chk({31'h0, rd <= 32'h3}, 32'h1);
    wr(tpm_pkg::OFF_STAT, 32'h0000_0004);
    rchk(tpm_pkg::OFF_STAT, 32'h0000_0004, 32'h0);
  endtask

  // Timer two counts rises of pin A; the prescaler takes and returns data while stopped.
  task automatic t_pin();
    wr(tpm_pkg::OFF_CNT, 32'h0000_0007);
    rchk(tpm_pkg::OFF_CNT, 32'hFFFF_FFFF, 32'h0000_0007);
    wr(tpm_pkg::OFF_SRC, {26'h0, tpm_pkg::SRC_PIN, 4'h0});
    wr(tpm_pkg::OFF_CNT + 8'h08, 32'h0000_0005);
    wr(tpm_pkg::OFF_CTRL, 32'h0000_0004);
    repeat (3) begin
      @(posedge aclk) pin_a <= 1'b1;
      repeat (2) @(posedge aclk);
      pin_a <= 1'b0;
      repeat (2) @(posedge aclk);
    end
    wr(tpm_pkg::OFF_CTRL, 32'h0);
    rchk(tpm_pkg::OFF_CNT + 8'h08, 32'hFFFF_FFFF, 32'h0000_0002);
    wr(tpm_pkg::OFF_SRC, 32'h0);
  endtask

  // Timer four with extension drives its pin; a stop leaves the pin still.
  task automatic t_t4();
    int highs;
    logic held;
    highs = 0;
    wr(tpm_pkg::OFF_T4H, 32'h0000_0001);
    wr(tpm_pkg::OFF_RLD + 8'h10, 32'h0000_0002);
    wr(tpm_pkg::OFF_CTRL, 32'h0000_0190);
    repeat (4) @(posedge aclk);
    repeat (10) begin
      @(negedge aclk);
      highs += b_out;
    end
    chk(highs, 32'h4);
    wr(tpm_pkg::OFF_CTRL, 32'h0000_0080);
    @(negedge aclk) held = b_out;
    repeat (8) @(negedge aclk);
    chk({31'h0, b_out}, {31'h0, held});
    wr(tpm_pkg::OFF_CTRL, 32'h0);
  endtask

  // Period measurement on the interrupt pin with a fast timer one source.
  task automatic t_meas();
    wr(tpm_pkg::OFF_IRQ0C, 32'h0000_0008);
    wr(tpm_pkg::OFF_RLD + 8'h04, 32'h0000_000F);
    wr(tpm_pkg::OFF_CNT + 8'h04, 32'h0000_0033);
    wr(tpm_pkg::OFF_STAT, 32'h0000_003F);
    wr(tpm_pkg::OFF_CTRL, 32'h0000_0040);
    meas_edge();
    rchk(tpm_pkg::OFF_CNT + 8'h04, 32'hFFFF_FFFF, 32'h0000_0033);
    wr(tpm_pkg::OFF_CTRL, 32'h0000_0042);
    meas_edge();
    repeat (80) @(posedge aclk);
    rchk(tpm_pkg::OFF_STAT, 32'h0000_0002, 32'h0);
    meas_edge();
    rchk(tpm_pkg::OFF_STAT, 32'h0000_0002, 32'h0000_0002);
    wr(tpm_pkg::OFF_CTRL, 32'h0);
  endtask

  // Unmapped place is refused; the output enable follows its control bit.
  task automatic t_bad();
    u_tpm_sw_model.rd(8'h3C, rd, resp);
    chk({30'h0, resp}, {30'h0, tpm_pkg::RESP_SLVERR});
    u_tpm_sw_model.wr(8'h3C, 32'h0000_00FF, resp);
    chk({30'h0, resp}, {30'h0, tpm_pkg::RESP_SLVERR});
    wr(tpm_pkg::OFF_CTRL, 32'h0000_0080);
    repeat (2) @(posedge aclk);
    chk({31'h0, b_oe}, 32'h1);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence after four cycles of reset.
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_wdog();
    t_count();
    t_meas();
    t_bad();
    t_t4();
    t_pin();
    complete_run();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    complete_run();
  end
endmodule // tpm_top_tb
